// file: hw/msp_consts.svh
// Purpose: Constants for the 1:n multiplex-section protection block
// Assumes: 40 MHz system clock, octet-wide section data
// Notes: Times are kept in their own units; cycle counts derive from them
`ifndef MSP_CONSTS_SVH
`define MSP_CONSTS_SVH
`define MSP_CLK_HZ 40000000
`define MSP_SWITCH_MS 50
`define MSP_SWITCH_CYC ((`MSP_SWITCH_MS * (`MSP_CLK_HZ / 1000)))
`define MSP_WTR_MIN_DEF 5
`define MSP_WTR_CYC_PER_MIN (60 * `MSP_CLK_HZ)
`define MSP_APS_CONFIRM 3
`define MSP_K1_POS 0
`define MSP_K2_POS 1
`define MSP_ALL_ONES 8'hFF
`define MSP_SRC_NONE 2'h0
`define MSP_SRC_EXTRA 2'h1
`define MSP_SRC_NORMAL 2'h2
`define MSP_SRC_TEST 2'h3
`define MSP_TEST_OCTET 8'hA5
// Status bit positions and width of the interrupt register
`define MSP_EV_SWITCH 0
`define MSP_EV_APS 1
`define MSP_EV_FAIL 2
`define MSP_EV_W 3
`endif

// file: hw/msp_pkg.sv
// Purpose: Types for the 1:n multiplex-section protection block
// Assumes: Constants come from msp_consts.svh
// Notes: Section data travels as one packed struct per section
package msp_pkg;
    typedef struct packed {
        logic [7:0] data;
        logic fs;
    } msp_oct_t;
    typedef struct packed {
        logic fail;
        logic degrade;
    } msp_cond_t;
    typedef enum logic [2:0] {
        MSP_CMD_NONE = 3'b000,
        MSP_CMD_LOCKOUT = 3'b001,
        MSP_CMD_FORCED = 3'b010,
        MSP_CMD_MANUAL = 3'b011,
        MSP_CMD_CLEAR = 3'b100,
        MSP_CMD_EXERCISE = 3'b101
    } msp_cmd_t;
    typedef enum logic [1:0] {
        MSP_ST_IDLE = 2'b00,
        MSP_ST_SWITCHED = 2'b01,
        MSP_ST_WTR = 2'b10
    } msp_state_t;
endpackage : msp_pkg

// file: hw/msp_prot.sv
// Purpose: 1:n multiplex-section protection: bridge, selector, trail and adaptation ends
// Assumes: Section clocks arrive as pins and are sampled on mclk_in; one shared frame
//          timing for all sections; K1 sits on the fs octet and K2 on the octet after it
// Notes: The annex priority machine is reduced to a request-priority compare
`timescale 1ns/1ps
`include "msp_consts.svh"
module msp_prot import msp_pkg::*; #(
    parameter int N = 14,
    parameter longint WTR_CYC = 64'h2_CB41_7800
) (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic sec_clk_in,
    input wire msp_oct_t [N-1:0] norm_in,
    input wire msp_oct_t extra_in,
    input wire msp_oct_t [N:0] line_in,
    input wire msp_cond_t [N:0] line_cond_in,
    input wire logic [12:0] aps_tx_in,
    input wire logic switching_kind_select_in,
    input wire logic revert_kind_select_in,
    input wire logic spare_traffic_enable_in,
    input wire logic [1:0] prot_src_sel_in,
    input wire logic [3:0] prot_bridge_idx_in,
    input wire logic [31:0] restore_wait_period_in,
    input wire msp_cmd_t operator_command_in,
    input wire logic [3:0] operator_index_in,
    input wire logic fail_report_enable_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    output msp_oct_t [N:0] line_out,
    output msp_oct_t [N-1:0] norm_out,
    output msp_oct_t extra_out,
    output logic extra_fail_out,
    output logic [N-1:0] norm_fail_out,
    output logic [N-1:0] norm_degrade_out,
    output logic [12:0] aps_rx_out,
    output logic trail_fail_flag_out,
    output logic reported_fail_fault_out,
    output logic protocol_failure_fault_out,
    output logic [15:0] switch_count_report_out,
    output logic sec_clk_out,
    output logic irq_out
);
    localparam logic [3:0] A_STATUS = 4'h0;
    localparam logic [3:0] A_MASK = 4'h1;
    localparam logic [3:0] A_STATE = 4'h2;
    localparam int SW_CYC = `MSP_SWITCH_CYC;

    // Section clock sampled by mclk_in; frame position moves on its rising edge, the K2 window on its fall
    logic sck_s1_reg, sck_s2_reg, sck_s3_reg;
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sck_s1_reg <= 1'b0;
            sck_s2_reg <= 1'b0;
            sck_s3_reg <= 1'b0;
        end else begin
            sck_s1_reg <= sec_clk_in;
            sck_s2_reg <= sck_s1_reg;
            sck_s3_reg <= sck_s2_reg;
        end
    end
    logic tick;
    assign tick = sck_s2_reg & ~sck_s3_reg;

    // Data pins pass two stages before use
    msp_oct_t [N:0] lin_s1_reg, lin_s2_reg;
    msp_oct_t [N-1:0] nin_s1_reg, nin_s2_reg;
    msp_oct_t ext_s1_reg, ext_s2_reg;
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lin_s1_reg <= '0;
            lin_s2_reg <= '0;
            nin_s1_reg <= '0;
            nin_s2_reg <= '0;
            ext_s1_reg <= '0;
            ext_s2_reg <= '0;
        end else begin
            lin_s1_reg <= line_in;
            lin_s2_reg <= lin_s1_reg;
            nin_s1_reg <= norm_in;
            nin_s2_reg <= nin_s1_reg;
            ext_s1_reg <= extra_in;
            ext_s2_reg <= ext_s1_reg;
        end
    end

    // Octet position within a frame, for APS byte location
    logic [1:0] pos_reg;
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pos_reg <= 2'h3;
        end else if (tick) begin
            if (lin_s2_reg[N].fs) pos_reg <= 2'h0;
            else if (pos_reg != 2'h3) pos_reg <= pos_reg + 2'h1;
        end
    end

    // Outgoing K2 spans the whole octet after the fs octet, bounded by section clock falls
    logic sck_fall;
    logic fs_mid_reg;
    logic k2_oct_reg;
    assign sck_fall = ~sck_s2_reg & sck_s3_reg;
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fs_mid_reg <= 1'b0;
            k2_oct_reg <= 1'b0;
        end else begin
            if (tick) fs_mid_reg <= lin_s2_reg[N].fs;
            if (sck_fall) k2_oct_reg <= fs_mid_reg;
        end
    end

    // Protection switch state: selected working index and controlling state
    msp_state_t state_reg;
    logic [3:0] sel_reg;
    logic [3:0] pend_reg;
    logic pend_valid_reg;
    logic lock_reg;
    logic by_cmd_reg;
    logic [31:0] wtr_cnt_reg;
    logic [31:0] sw_cnt_reg;
    logic fop_reg;
    logic [15:0] psc_reg;

    // Highest-priority request: lockout blocks, forced and manual alike, fail, degrade
    logic req_any;
    logic [3:0] req_idx;
    always_comb begin
        req_any = 1'b0;
        req_idx = 4'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (line_cond_in[i].degrade) begin
                req_any = 1'b1;
                req_idx = 4'(i);
            end
        end
        for (int i = N - 1; i >= 0; i--) begin
            if (line_cond_in[i].fail) begin
                req_any = 1'b1;
                req_idx = 4'(i);
            end
        end
        if (lock_reg || line_cond_in[N].fail) begin
            req_any = 1'b0;
        end
    end

    logic cmd_req;
    assign cmd_req = (operator_command_in == MSP_CMD_FORCED)
                  || (operator_command_in == MSP_CMD_MANUAL);

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lock_reg <= 1'b0;
        end else if (operator_command_in == MSP_CMD_LOCKOUT) begin
            lock_reg <= 1'b1;
        end else if (operator_command_in == MSP_CMD_CLEAR) begin
            lock_reg <= 1'b0;
        end
    end

    // Decision is made at once; it is taken up at the next frame start
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= MSP_ST_IDLE;
            pend_reg <= 4'h0;
            pend_valid_reg <= 1'b0;
            wtr_cnt_reg <= '0;
            by_cmd_reg <= 1'b0;
            psc_reg <= '0;
        end else begin
            unique case (state_reg)
                MSP_ST_IDLE: begin
                    if (!lock_reg && cmd_req && operator_index_in < 4'(N)) begin
                        pend_reg <= operator_index_in;
                        by_cmd_reg <= 1'b1;
                        pend_valid_reg <= 1'b1;
                        state_reg <= MSP_ST_SWITCHED;
                        psc_reg <= psc_reg + 16'h1;
                    end else if (req_any) begin
                        pend_reg <= req_idx;
                        by_cmd_reg <= 1'b0;
                        pend_valid_reg <= 1'b1;
                        state_reg <= MSP_ST_SWITCHED;
                        psc_reg <= psc_reg + 16'h1;
                    end
                end
                MSP_ST_SWITCHED: begin
                    if (lock_reg || operator_command_in == MSP_CMD_CLEAR) begin
                        pend_valid_reg <= 1'b0;
                        state_reg <= MSP_ST_IDLE;
                    end else if (!by_cmd_reg && !req_any && revert_kind_select_in) begin
                        // Operator switches hold until clear or lockout; a recovered fail or degrade reverts when revertive
                        wtr_cnt_reg <= restore_wait_period_in;
                        state_reg <= MSP_ST_WTR;
                    end
                end
                MSP_ST_WTR: begin
                    if (req_any || lock_reg) begin
                        state_reg <= lock_reg ? MSP_ST_IDLE : MSP_ST_SWITCHED;
                        pend_valid_reg <= !lock_reg;
                    end else if (wtr_cnt_reg == '0) begin
                        pend_valid_reg <= 1'b0;
                        state_reg <= MSP_ST_IDLE;
                    end else begin
                        wtr_cnt_reg <= wtr_cnt_reg - 32'h1;
                    end
                end
                default: state_reg <= MSP_ST_IDLE;
            endcase
        end
    end

    // Applied selection moves only on protection frame start
    logic sel_valid_reg;
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sel_reg <= 4'h0;
            sel_valid_reg <= 1'b0;
        end else if (tick && lin_s2_reg[N].fs) begin
            sel_reg <= pend_reg;
            sel_valid_reg <= pend_valid_reg;
        end
    end

    // Switch time guard: a request not applied within 50 ms is a protocol fault
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sw_cnt_reg <= '0;
            fop_reg <= 1'b0;
        end else if (pend_valid_reg != sel_valid_reg || pend_reg != sel_reg) begin
            sw_cnt_reg <= sw_cnt_reg + 32'h1;
            if (sw_cnt_reg >= 32'(SW_CYC)) fop_reg <= 1'b1;
        end else begin
            sw_cnt_reg <= '0;
        end
    end

    // APS extraction: protection instance only, three-frame confirmation
    logic [12:0] aps_cur_reg, aps_last_reg, aps_acc_reg;
    logic [1:0] aps_same_reg;
    logic aps_new;
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            aps_cur_reg <= '0;
            aps_last_reg <= '0;
            aps_acc_reg <= '0;
            aps_same_reg <= 2'h0;
        end else if (tick) begin
            if (pos_reg == 2'h3 && lin_s2_reg[N].fs) begin
                aps_cur_reg[12:5] <= lin_s2_reg[N].data;
            end else if (pos_reg == 2'(`MSP_K1_POS)) begin
                aps_cur_reg[4:0] <= lin_s2_reg[N].data[7:3];
                if ({aps_cur_reg[12:5], lin_s2_reg[N].data[7:3]} == aps_last_reg) begin
                    if (aps_same_reg != 2'(`MSP_APS_CONFIRM - 1)) begin
                        aps_same_reg <= aps_same_reg + 2'h1;
                    end else begin
                        aps_acc_reg <= aps_last_reg;
                    end
                end else begin
                    aps_same_reg <= 2'h1;
                end
                aps_last_reg <= {aps_cur_reg[12:5], lin_s2_reg[N].data[7:3]};
            end
        end
    end
    assign aps_new = (aps_acc_reg != aps_rx_out);

    // Source direction and sink selection, registered outputs
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            line_out <= '0;
            norm_out <= '0;
            extra_out <= '0;
            extra_fail_out <= 1'b0;
            norm_fail_out <= '0;
            norm_degrade_out <= '0;
            aps_rx_out <= '0;
            sec_clk_out <= 1'b0;
        end else begin
            sec_clk_out <= sck_s2_reg;
            aps_rx_out <= aps_acc_reg;
            for (int i = 0; i < N; i++) begin
                line_out[i] <= nin_s2_reg[i];
                if (sel_valid_reg && sel_reg == 4'(i)) begin
                    norm_out[i] <= lin_s2_reg[N];
                    norm_fail_out[i] <= line_cond_in[N].fail;
                    norm_degrade_out[i] <= line_cond_in[N].degrade;
                end else begin
                    norm_out[i] <= lin_s2_reg[i];
                    norm_fail_out[i] <= line_cond_in[i].fail;
                    norm_degrade_out[i] <= line_cond_in[i].degrade;
                end
            end
            if (sel_valid_reg) begin
                line_out[N] <= nin_s2_reg[sel_reg];
            end else if (prot_src_sel_in == `MSP_SRC_EXTRA && spare_traffic_enable_in) begin
                line_out[N] <= ext_s2_reg;
            end else if (prot_src_sel_in == `MSP_SRC_NORMAL && prot_bridge_idx_in < 4'(N)) begin
                line_out[N] <= nin_s2_reg[prot_bridge_idx_in];
            end else if (prot_src_sel_in == `MSP_SRC_TEST) begin
                line_out[N] <= '{data: `MSP_TEST_OCTET, fs: nin_s2_reg[0].fs};
            end else begin
                line_out[N] <= '{data: `MSP_ALL_ONES, fs: nin_s2_reg[0].fs};
            end
            // APS bytes are merged onto the protection line at their positions
            if (nin_s2_reg[0].fs) begin
                line_out[N].data <= aps_tx_in[12:5];
            end else if (k2_oct_reg) begin
                line_out[N].data <= {aps_tx_in[4:0], 3'h0};
            end
            if (sel_valid_reg) begin
                extra_out <= '{data: `MSP_ALL_ONES, fs: lin_s2_reg[N].fs};
                extra_fail_out <= 1'b1;
            end else begin
                extra_out <= lin_s2_reg[N];
                extra_fail_out <= line_cond_in[N].fail;
            end
        end
    end

    // Per-section fail levels gathered into one vector
    logic [N:0] cond_fail;
    for (genvar g = 0; g <= N; g++) begin : g_fail
        assign cond_fail[g] = line_cond_in[g].fail;
    end

    // Trail sink: fail when every connection is gone
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            trail_fail_flag_out <= 1'b0;
            reported_fail_fault_out <= 1'b0;
            protocol_failure_fault_out <= 1'b0;
            switch_count_report_out <= '0;
        end else begin
            trail_fail_flag_out <= &cond_fail;
            reported_fail_fault_out <= (&cond_fail) && fail_report_enable_in;
            protocol_failure_fault_out <= fop_reg;
            switch_count_report_out <= psc_reg;
        end
    end

    // Interrupt status: set wins over write-one-to-clear
    logic [`MSP_EV_W-1:0] ev, stat_reg, mask_reg;
    assign ev = {trail_fail_flag_out, aps_new, state_reg == MSP_ST_IDLE && req_any};
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stat_reg <= '0;
            mask_reg <= '0;
            reg_rdata_out <= '0;
            irq_out <= 1'b0;
        end else begin
            stat_reg <= (stat_reg & ~((reg_wr_in && reg_addr_in == A_STATUS) ?
                         reg_wdata_in[`MSP_EV_W-1:0] : '0)) | ev;
            if (reg_wr_in && reg_addr_in == A_MASK) mask_reg <= reg_wdata_in[`MSP_EV_W-1:0];
            irq_out <= |(stat_reg & mask_reg);
            reg_rdata_out <= '0;
            if (reg_rd_in) begin
                unique case (reg_addr_in)
                    A_STATUS: reg_rdata_out <= 32'(stat_reg);
                    A_MASK: reg_rdata_out <= 32'(mask_reg);
                    A_STATE: reg_rdata_out <= {16'h0, psc_reg[7:0], 1'b0, sel_valid_reg,
                                               state_reg, sel_reg};
                    default: reg_rdata_out <= '0;
                endcase
            end
        end
    end

    // Idle configuration changes leave the selection untouched
    a_idle_no_sel: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (state_reg == MSP_ST_IDLE && !pend_valid_reg) |=> !sel_valid_reg || $past(sel_valid_reg))
        else $error("selection moved while idle");
    a_sel_frame: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        $changed(sel_reg) |-> $past(tick && lin_s2_reg[N].fs))
        else $error("selector moved off frame start");
    a_extra_ais: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        sel_valid_reg |=> extra_fail_out && extra_out.data == 8'hFF)
        else $error("extra traffic not forced to all-ones");
    a_trail_fail: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (&cond_fail) |=> trail_fail_flag_out)
        else $error("trail fail not raised");
    a_fault_gate: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        !fail_report_enable_in |=> !reported_fail_fault_out)
        else $error("fault reported while disabled");
    a_work_feed: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        1'b1 |=> line_out[0] == $past(nin_s2_reg[0]))
        else $error("working output not fed from normal");
    a_aps_hold: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        $changed(aps_acc_reg) |-> $past(aps_same_reg) == 2'h2)
        else $error("APS accepted before three frames");
    a_wtr_wait: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (state_reg == MSP_ST_WTR && wtr_cnt_reg != '0 && !req_any && !lock_reg)
        |=> pend_valid_reg)
        else $error("reverted before restore period");
endmodule : msp_prot

// file: tb/msp_far_end.sv
// Purpose: Far-end section model: link clock and framed octets on every line
// Assumes: 8-octet frames; fs and K1 on octet 0, K2 on octet 1
// Notes: Link clock runs free as section timing does; working lines carry decoy K bytes
`timescale 1ns/1ps
module msp_far_end import msp_pkg::*; #(
    parameter int N = 14
) (
    input wire logic [12:0] aps_in,
    output logic sec_clk_out,
    output msp_oct_t [N:0] line_out,
    output logic [2:0] octet_out
);
    logic [12:0] aps_frame;
    logic [7:0] k_byte;
    initial begin
        sec_clk_out = 1'h0;
        octet_out = 3'h7;
        aps_frame = 13'h0000;
        line_out = '0;
        #37;
        forever begin
            #100 sec_clk_out = 1'h1;
            #100 sec_clk_out = 1'h0;
            octet_out = octet_out + 3'h1;
            if (octet_out == 3'h0) begin
                aps_frame = aps_in;
            end
            k_byte = (octet_out == 3'h0) ? aps_frame[12:5] : {aps_frame[4:0], 3'h0};
            for (int i = 0; i <= N; i++) begin
                line_out[i].fs = (octet_out == 3'h0);
                if (octet_out > 3'h1) begin
                    line_out[i].data = (i == N) ? 8'hE0 : 8'h10 + 8'(i);
                end else begin
                    line_out[i].data = (i == N) ? k_byte : ~k_byte;
                end
            end
        end
    end
endmodule : msp_far_end

// file: tb/tb_ms_one_to_n_protection.sv
// Purpose: Self-checking bench for the 1:n section protection block
// Assumes: 14 working sections, far-end frames of 8 octets
// Notes: Traffic checks sample mid-frame, where every line carries its fill octet
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD %s expected %h seen %h", nm, e, g); end end
module tb_ms_one_to_n_protection import msp_pkg::*; ();
    localparam int N = 14;
    typedef struct {int sig; int idx; logic [31:0] exp; logic [31:0] mask;} msp_note_t;
    logic mclk_in, rstn_in, sec_clk_in;
    msp_oct_t [N-1:0] norm_in;
    msp_oct_t extra_in;
    msp_oct_t [N:0] line_in;
    msp_cond_t [N:0] line_cond_in;
    logic [12:0] aps_tx_in, fe_aps, aps_v;
    logic switching_kind_select_in, revert_kind_select_in, spare_traffic_enable_in;
    logic [1:0] prot_src_sel_in;
    logic [3:0] prot_bridge_idx_in, operator_index_in, reg_addr_in;
    logic [31:0] restore_wait_period_in, reg_wdata_in, reg_rdata_out;
    msp_cmd_t operator_command_in;
    logic fail_report_enable_in, reg_wr_in, reg_rd_in;
    msp_oct_t [N:0] line_out;
    msp_oct_t [N-1:0] norm_out;
    msp_oct_t extra_out;
    logic extra_fail_out, trail_fail_flag_out, reported_fail_fault_out;
    logic protocol_failure_fault_out, sec_clk_out, irq_out;
    logic [N-1:0] norm_fail_out, norm_degrade_out;
    logic [12:0] aps_rx_out;
    logic [15:0] switch_count_report_out;
    logic [2:0] octet;
    logic [7:0] norm_data [N];
    logic [7:0] src_exp [4];
    logic rd_seen = 1'h0;
    int fail_count, comparisons, bidx;
    msp_note_t notes[$];
    string names [7] = '{"norm_out", "line_out", "extra_out", "extra_fail", "aps_rx",
        "flags", "reg_rdata"};
    msp_cmd_t cmds [8] = '{MSP_CMD_LOCKOUT, MSP_CMD_FORCED, MSP_CMD_CLEAR, MSP_CMD_FORCED,
        MSP_CMD_CLEAR, MSP_CMD_MANUAL, MSP_CMD_CLEAR, MSP_CMD_EXERCISE};
    int idxs [8] = '{0, 0, 0, 3, 3, 1, 1, 2};
    logic [7:0] sws = 8'h28;

    msp_prot #(.N(N)) u_msp_prot (.mclk_in, .rstn_in, .sec_clk_in, .norm_in, .extra_in,
        .line_in, .line_cond_in, .aps_tx_in, .switching_kind_select_in,
        .revert_kind_select_in, .spare_traffic_enable_in, .prot_src_sel_in,
        .prot_bridge_idx_in, .restore_wait_period_in, .operator_command_in,
        .operator_index_in, .fail_report_enable_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out, .line_out, .norm_out, .extra_out, .extra_fail_out,
        .norm_fail_out, .norm_degrade_out, .aps_rx_out, .trail_fail_flag_out,
        .reported_fail_fault_out, .protocol_failure_fault_out, .switch_count_report_out,
        .sec_clk_out, .irq_out);
    msp_far_end #(.N(N)) u_msp_far_end (.aps_in(fe_aps), .sec_clk_out(sec_clk_in),
        .line_out(line_in), .octet_out(octet));

    initial mclk_in = 1'h0;
    always #12.5 mclk_in = ~mclk_in;
    // Normal inputs framed on the protection line's frame start
    always @(posedge mclk_in) begin
        for (int i = 0; i < N; i++) norm_in[i] <= '{norm_data[i], line_in[N].fs};
    end

    function automatic logic [31:0] pick(int sig, int idx);
        case (sig)
            0: return {24'h0, norm_out[idx].data};
            1: return {24'h0, line_out[idx].data};
            2: return {24'h0, extra_out.data};
            3: return {30'h0, sec_clk_out, extra_fail_out};
            4: return {19'h0, aps_rx_out};
            5: return {switch_count_report_out[7:0], norm_fail_out, 6'h0,
                protocol_failure_fault_out, irq_out, reported_fail_fault_out, trail_fail_flag_out};
            default: return reg_rdata_out;
        endcase
    endfunction : pick
    task automatic check_one();
        msp_note_t n;
        n = notes.pop_front();
        `CHK(names[n.sig], n.exp & n.mask, pick(n.sig, n.idx) & n.mask)
    endtask : check_one
    // Read data stands only in the cycle after the strobe
    always @(posedge mclk_in) begin
        if (rd_seen) check_one();
        rd_seen <= reg_rd_in;
    end
    always @(negedge mclk_in) begin
        while (notes.size() > 0 && notes[0].sig != 6) check_one();
    end

    task automatic chk(int sig, int idx, logic [31:0] e, logic [31:0] m = 32'hFFFFFFFF);
        notes.push_back('{sig, idx, e, m});
    endtask : chk
    task automatic wr(logic [3:0] a, logic [31:0] d);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'h1;
        @(posedge mclk_in);
        reg_wr_in <= 1'h0;
        @(posedge mclk_in);
    endtask : wr
    task automatic rd(logic [3:0] a, logic [31:0] e, logic [31:0] m = 32'hFFFFFFFF);
        notes.push_back('{6, 0, e, m});
        reg_addr_in <= a;
        reg_rd_in <= 1'h1;
        @(posedge mclk_in);
        reg_rd_in <= 1'h0;
        @(posedge mclk_in);
    endtask : rd
    task automatic at_octet(logic [2:0] k);
        do @(posedge sec_clk_in); while (octet !== k);
        repeat (6) @(posedge mclk_in);
    endtask : at_octet
    task automatic frames(int n);
        repeat (n) at_octet(3'h4);
    endtask : frames
    task automatic cmd(msp_cmd_t c, int idx, logic sw);
        operator_command_in <= c;
        operator_index_in <= 4'(idx);
        @(posedge mclk_in);
        operator_command_in <= MSP_CMD_NONE;
        frames(8);
        chk(0, idx, sw ? 32'hE0 : 32'(8'h10 + idx));
        chk(3, 0, {30'h0, 1'h1, sw});
        chk(2, 0, sw ? 32'hFF : 32'hE0);
    endtask : cmd
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (40000) @(posedge mclk_in);
        fail_count++;
        stop_test();
    end

    initial begin
        rstn_in = 1'h0; norm_in = '0; extra_in = '0; line_cond_in = '0; aps_tx_in = '0;
        switching_kind_select_in = 1'h0; revert_kind_select_in = 1'h1;
        spare_traffic_enable_in = 1'h1; prot_src_sel_in = 2'h0; prot_bridge_idx_in = 4'h0;
        restore_wait_period_in = 32'h190; operator_command_in = MSP_CMD_NONE;
        operator_index_in = 4'h0; fail_report_enable_in = 1'h0; reg_addr_in = 4'h0;
        reg_wdata_in = '0; reg_wr_in = 1'h0; reg_rd_in = 1'h0; fe_aps = '0;
        fail_count = 0; comparisons = 0;
        void'($urandom(89069));
        for (int i = 0; i < N; i++) norm_data[i] = 8'($urandom);
        repeat (2) @(posedge mclk_in);
        rstn_in <= 1'h1;
        @(posedge mclk_in);
        extra_in <= '{8'($urandom), 1'h0};
        aps_tx_in <= 13'($urandom);
        // Status, mask and the level interrupt around a protection trail fail
        rd(4'h0, 32'h0); wr(4'h0, 32'h7); wr(4'h1, 32'h4); rd(4'h1, 32'h4);
        // Every section failing leaves no connection, so the trail fails
        line_cond_in <= {(N + 1){2'h2}};
        repeat (4) @(posedge mclk_in);
        chk(5, 0, 32'h00FFFC05);
        fail_report_enable_in <= 1'h1;
        repeat (4) @(posedge mclk_in);
        chk(5, 0, 32'h00FFFC07);
        rd(4'h0, 32'h4, 32'h4); wr(4'h1, 32'h0);
        repeat (3) @(posedge mclk_in);
        chk(5, 0, 32'h00FFFC03);
        line_cond_in <= '0;
        wr(4'h1, 32'h4); wr(4'h0, 32'h4);
        repeat (3) @(posedge mclk_in);
        chk(5, 0, 32'h0);
        rd(4'h0, 32'h0, 32'h4); rd(4'h9, 32'h0);
        // Protection source kinds while configuration changes under live traffic
        bidx = $urandom_range(N - 1);
        src_exp = '{8'hFF, extra_in.data, norm_data[bidx], 8'hA5};
        for (int k = 0; k < 4; k++) begin
            prot_src_sel_in <= 2'(k);
            prot_bridge_idx_in <= 4'(bidx);
            switching_kind_select_in <= k[0];
            restore_wait_period_in <= 32'(100 + k * 100);
            frames(1);
            chk(1, N, src_exp[k]);
            chk(1, k, norm_data[k]);
            chk(0, 13 - k, 8'h1D - k);
        end
        at_octet(3'h0); chk(1, N, aps_tx_in[12:5]);
        at_octet(3'h1); chk(1, N, {aps_tx_in[4:0], 3'h0}, 32'hF8);
        aps_v = 13'($urandom) | 13'h1000;
        frames(1);
        fe_aps <= aps_v;
        frames(2); chk(4, 0, 32'h0);
        frames(1); chk(4, 0, aps_v);
        for (int j = 0; j < 8; j++) cmd(cmds[j], idxs[j], sws[j]);
        line_cond_in[2].fail <= 1'h1;
        frames(2); chk(0, 2, 32'hE0);
        chk(3, 0, 32'h3);
        chk(5, 0, 32'h03000000, 32'hFF001008);
        line_cond_in[2].fail <= 1'h0;
        frames(2); chk(0, 2, 32'hE0);
        frames(6); chk(0, 2, 32'h12);
        // Let the checker drain the last notes before the verdict
        @(negedge mclk_in);
        @(posedge mclk_in);
        if (notes.size() > 0) fail_count++;
        stop_test();
    end
endmodule : tb_ms_one_to_n_protection
